/* File: src/sar_adc_pkg.sv */
package sar_adc_pkg;

	// ==========================================================
	// Widths.
	localparam int ADDR_W   = 16;
	localparam int DATA_W   = 16;
	localparam int RES_W    = 10;
	localparam int CH_W     = 3;
	localparam int NUM_PINS = 6;
	localparam int MODE_W   = 8;
	localparam int DIV_W    = 5;
	localparam int STEP_W   = 6;

	// ==========================================================
	// Register addresses.
	localparam logic [ADDR_W-1:0] MODE_ADDR   = 16'hFF8D;
	localparam logic [ADDR_W-1:0] CHSEL_ADDR  = 16'hFF8E;
	localparam logic [ADDR_W-1:0] RES_LO_ADDR = 16'hFF06;
	localparam logic [ADDR_W-1:0] RES_HI_ADDR = 16'hFF07;
	localparam logic [ADDR_W-1:0] UPPER_ADDR  = 16'hFF1F;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'hFF1E;
	localparam logic [ADDR_W-1:0] PINCFG_ADDR = 16'hFF2E;

	// ==========================================================
	// Mode register fields.
	localparam int RUN_BIT = 7;
	localparam int FR_MSB  = 6;
	localparam int FR_LSB  = 3;
	localparam int LV_MSB  = 2;
	localparam int LV_LSB  = 1;
	localparam int CE_BIT  = 0;

	// Status register fields.
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_INVALID_BIT = 1;
	localparam int STAT_COMP_ON_BIT = 2;

	// ==========================================================
	// Reset values.
	localparam logic [MODE_W-1:0]   MODE_RESET   = 8'h00;
	localparam logic [CH_W-1:0]     CHSEL_RESET  = 3'h0;
	localparam logic [NUM_PINS-1:0] PINCFG_RESET = 6'h3F;
	localparam logic [DATA_W-1:0]   RESULT_RESET = 16'h0000;
	localparam logic [7:0]          UPPER_RESET  = 8'h00;
	localparam int                  RES_PAD_W    = DATA_W - RES_W;
	localparam logic [RES_PAD_W-1:0] RES_PAD     = 6'h00;
	localparam logic [RES_W-1:0]    RES_MSB_MASK = 10'h200;

	// ==========================================================
	// Timing: conversion clocks per conversion and divider ratios.
	localparam logic [1:0]        LV_LOW_RANGE      = 2'b01;
	localparam logic [STEP_W-1:0] CONV_CLKS_NORMAL  = 6'h16;
	localparam logic [STEP_W-1:0] CONV_CLKS_LOW     = 6'h28;
	localparam logic [STEP_W-1:0] SAMPLE_CLKS_NORMAL = CONV_CLKS_NORMAL - STEP_W'(RES_W + 1);
	localparam logic [STEP_W-1:0] SAMPLE_CLKS_LOW    = CONV_CLKS_LOW - STEP_W'(RES_W + 1);
	localparam logic [DIV_W-1:0]  DIV_BY_16 = 5'h10;
	localparam logic [DIV_W-1:0]  DIV_BY_12 = 5'h0C;
	localparam logic [DIV_W-1:0]  DIV_BY_8  = 5'h08;
	localparam logic [DIV_W-1:0]  DIV_BY_6  = 5'h06;
	localparam logic [DIV_W-1:0]  DIV_BY_4  = 5'h04;
	localparam logic [DIV_W-1:0]  DIV_BY_3  = 5'h03;
	localparam logic [DIV_W-1:0]  DIV_BY_2  = 5'h02;

	// ==========================================================
	// Conversion sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0001,
		ST_SAMPLE   = 4'b0010,
		ST_CONVERT  = 4'b0100,
		ST_TRANSFER = 4'b1000
	} conv_state_t;

	// Maps the conversion-time field to the peripheral clock divider.
	// Prohibited codes fall back to the slowest ratio.
	function automatic logic [DIV_W-1:0] conv_divider(input logic [3:0] fr);
		logic [DIV_W-1:0] d;
		d = DIV_BY_16;
		case (fr)
			4'h0: d = DIV_BY_12;
			4'h1: d = DIV_BY_8;
			4'h2: d = DIV_BY_6;
			4'h3: d = DIV_BY_4;
			4'h4: d = DIV_BY_3;
			4'h5: d = DIV_BY_2;
			default: d = DIV_BY_16;
		endcase
		return d;
	endfunction

endpackage

/* File: src/conv_clock_divider.sv */
module conv_clock_divider
	import sar_adc_pkg::*;
(
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          enable,
	input  wire logic [sar_adc_pkg::DIV_W-1:0] ratio,
	output logic                               tick
);

	// ==========================================================
	// Counter state.
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic             wrap;

	// The counter restarts while disabled so every conversion starts in phase.
	assign wrap  = (cnt_q == (ratio - DIV_W'(1)));
	assign tick  = enable & wrap;
	assign cnt_d = (!enable || wrap) ? '0 : cnt_q + DIV_W'(1);

	// Counter register.
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

/* File: src/sar_adc_control.sv */
// What this block does
// - Converts the chosen one of six inputs at 10 bits repeatedly while running.
// - Pulses the completion interrupt once at the end of each conversion.
// - Samples the selected input at start and holds it through conversion.
// - Resolves one bit per step, most significant bit first, down to bit zero.
// - After the last bit, copies the approximation into both result registers.
// - Wide result holds the ten bits at the top, low six bits read zero.
// - Byte result holds the upper eight bits of each conversion.
// - Result reads flag a bus wait cycle; software avoids them with clock stopped.
// - Mode register at its fixed address takes byte writes, resets to zero.
// - Mode bit 7 runs, bits 6-3 time, bits 2-1 range, bit 0 comparator.
// - Run and comparator enable both low means stopped and comparator unpowered.
// - Run low with comparator enable high powers the comparator only, no conversion.
// - Run high converts regardless; without comparator enable the first result is invalid.
// - Mode writes flag a bus wait cycle; software avoids them with clock stopped.
// - Pin configuration register sets each of six pins analog or digital.
// - Channel select register chooses which pin feeds the sample and hold.
// - Wide result high byte holds upper eight bits, low byte top two bits the rest.
//
// Design decision made here: strobed register access.
module sar_adc_control
	import sar_adc_pkg::*;
(
	input  wire logic                             mclk,
	input  wire logic                             rst,
	input  wire logic [sar_adc_pkg::ADDR_W-1:0]   bus_addr,
	input  wire logic [sar_adc_pkg::DATA_W-1:0]   bus_wdata,
	input  wire logic                             bus_wr,
	input  wire logic                             bus_rd,
	output logic      [sar_adc_pkg::DATA_W-1:0]   bus_rdata,
	output logic                                  bus_wait,
	input  wire logic                             comp_pin,
	output logic      [sar_adc_pkg::RES_W-1:0]    trial_code,
	output logic                                  sample_track,
	output logic                                  hold_active,
	output logic                                  comparator_power,
	output logic      [sar_adc_pkg::CH_W-1:0]     input_mux_sel,
	output logic      [sar_adc_pkg::NUM_PINS-1:0] analog_pin_en,
	output logic      [1:0]                       voltage_range,
	output logic                                  conversion_done_irq
);

	// ==========================================================
	// Declarations.
	logic [MODE_W-1:0]   mode_q;
	logic [CH_W-1:0]     chsel_q;
	logic [NUM_PINS-1:0] pincfg_q;
	logic [DATA_W-1:0]   result_wide_q;
	logic [7:0]          result_upper_q;
	logic [DATA_W-1:0]   rdata_q;
	logic [DATA_W-1:0]   rdata_d;
	logic                sync1_q;
	logic                sync2_q;
	logic                sync3_q;
	logic                comp_q;
	conv_state_t         state_q;
	conv_state_t         state_d;
	logic [RES_W-1:0]    sar_q;
	logic [RES_W-1:0]    sar_d;
	logic [RES_W-1:0]    mask_q;
	logic [RES_W-1:0]    mask_d;
	logic [RES_W-1:0]    trial_q;
	logic [STEP_W-1:0]   step_q;
	logic [STEP_W-1:0]   step_d;
	logic [CH_W-1:0]     chan_hold_q;
	logic                first_q;
	logic                ce_at_start_q;
	logic                invalid_q;
	logic                done_q;
	logic                ad_tick;
	logic                run_bit;
	logic                ce_bit;
	logic [3:0]          fr_field;
	logic [1:0]          lv_field;
	logic [STEP_W-1:0]   sample_clks;
	logic                hit_mode;
	logic                hit_chsel;
	logic                hit_pincfg;
	logic                hit_res_lo;
	logic                hit_res_hi;
	logic                hit_upper;
	logic                hit_status;
	logic                wr_mode;
	logic                start_conv;
	logic                do_transfer;
	logic                last_bit;
	logic [DATA_W-1:0]   wide_value;
	logic [DATA_W-1:0]   status_word;

	// ==========================================================
	// Mode field extraction and pin-level controls.

	// Mode fields feed the sequencer and the analog front end.
	assign run_bit     = mode_q[RUN_BIT];
	assign ce_bit      = mode_q[CE_BIT];
	assign fr_field    = mode_q[FR_MSB:FR_LSB];
	assign lv_field    = mode_q[LV_MSB:LV_LSB];
	assign sample_clks = (lv_field == LV_LOW_RANGE) ? SAMPLE_CLKS_LOW : SAMPLE_CLKS_NORMAL;

	// The comparator is powered whenever either control bit is set.
	assign comparator_power = run_bit | ce_bit;
	assign voltage_range    = lv_field;
	assign analog_pin_en    = pincfg_q;
	assign input_mux_sel    = chan_hold_q;
	assign trial_code       = trial_q;

	// Track while sampling, hold once the bit steps begin.
	assign sample_track = state_q[1];
	assign hold_active  = state_q[2] | state_q[3];
	assign conversion_done_irq = done_q;

	// ==========================================================
	// Register bus decode.

	// Address comparisons shared by writes, reads and the wait flag.
	assign hit_mode   = (bus_addr == MODE_ADDR);
	assign hit_chsel  = (bus_addr == CHSEL_ADDR);
	assign hit_pincfg = (bus_addr == PINCFG_ADDR);
	assign hit_res_lo = (bus_addr == RES_LO_ADDR);
	assign hit_res_hi = (bus_addr == RES_HI_ADDR);
	assign hit_upper  = (bus_addr == UPPER_ADDR);
	assign hit_status = (bus_addr == STATUS_ADDR);
	assign wr_mode    = bus_wr & hit_mode;

	// A result read or mode write marks the access as one that stretches the cycle.
	assign bus_wait = (bus_rd & (hit_res_lo | hit_res_hi | hit_upper)) | wr_mode;

	// Status word shows sequencer activity and the validity of the last result.
	assign status_word = {{(DATA_W - 3){1'b0}}, comparator_power, invalid_q, ~state_q[0]};

	// Read data selection, latched for the following cycle.
	always_comb begin
		rdata_d = '0;
		if (!bus_rd) begin
			rdata_d = '0;
		end else if (hit_mode) begin
			rdata_d = {8'h00, mode_q};
		end else if (hit_chsel) begin
			rdata_d = {{(DATA_W - CH_W){1'b0}}, chsel_q};
		end else if (hit_pincfg) begin
			rdata_d = {{(DATA_W - NUM_PINS){1'b0}}, pincfg_q};
		end else if (hit_res_lo) begin
			rdata_d = result_wide_q;
		end else if (hit_res_hi) begin
			rdata_d = {8'h00, result_wide_q[DATA_W-1:8]};
		end else if (hit_upper) begin
			rdata_d = {8'h00, result_upper_q};
		end else if (hit_status) begin
			rdata_d = status_word;
		end else begin
			rdata_d = '0;
		end
	end

	assign bus_rdata = rdata_q;

	// Read data register: valid only in the cycle after the read strobe.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Software-written control registers.
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_q   <= MODE_RESET;
			chsel_q  <= CHSEL_RESET;
			pincfg_q <= PINCFG_RESET;
		end else if (bus_wr) begin
			if (hit_mode) begin
				mode_q <= bus_wdata[MODE_W-1:0];
			end
			if (hit_chsel) begin
				chsel_q <= bus_wdata[CH_W-1:0];
			end
			if (hit_pincfg) begin
				pincfg_q <= bus_wdata[NUM_PINS-1:0];
			end
		end
	end

	// ==========================================================
	// Comparator input synchroniser and agreement filter.

	// Three stages; the decision follows only once stages two and three agree.
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			comp_q  <= 1'b0;
		end else begin
			sync1_q <= comp_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q) begin
				comp_q <= sync3_q;
			end
		end
	end

	// ==========================================================
	// Conversion clock.

	// The conversion clock only runs while conversion is enabled.
	conv_clock_divider u_div (
		.mclk   (mclk),
		.rst    (rst),
		.enable (run_bit),
		.ratio  (conv_divider(fr_field)),
		.tick   (ad_tick)
	);

	// ==========================================================
	// Conversion sequencer.

	assign start_conv  = state_q[0] & run_bit;
	assign last_bit    = mask_q[0];
	assign do_transfer = state_q[3] & ad_tick & run_bit;

	// Next-state, step counter and approximation update.
	always_comb begin
		state_d = state_q;
		step_d  = step_q;
		sar_d   = sar_q;
		mask_d  = mask_q;
		if (!run_bit) begin
			state_d = ST_IDLE;
			mask_d  = '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_d = ST_SAMPLE;
					step_d  = sample_clks - STEP_W'(1);
				end
				ST_SAMPLE: begin
					if (ad_tick) begin
						if (step_q == '0) begin
							state_d = ST_CONVERT;
							sar_d   = '0;
							mask_d  = RES_MSB_MASK;
						end else begin
							step_d = step_q - STEP_W'(1);
						end
					end
				end
				ST_CONVERT: begin
					if (ad_tick) begin
						sar_d  = comp_q ? (sar_q | mask_q) : sar_q;
						mask_d = mask_q >> 1;
						if (last_bit) begin
							state_d = ST_TRANSFER;
						end
					end
				end
				ST_TRANSFER: begin
					if (ad_tick) begin
						state_d = ST_SAMPLE;
						step_d  = sample_clks - STEP_W'(1);
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers; the trial code follows the next approximation.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			step_q  <= '0;
			sar_q   <= '0;
			mask_q  <= '0;
			trial_q <= '0;
		end else begin
			state_q <= state_d;
			step_q  <= step_d;
			sar_q   <= sar_d;
			mask_q  <= mask_d;
			trial_q <= sar_d | mask_d;
		end
	end

	// Channel is frozen when sampling begins and held to the end of conversion.
	always_ff @(posedge mclk) begin
		if (rst) begin
			chan_hold_q <= CHSEL_RESET;
		end else if ((state_q[0] | state_q[3]) && state_d == ST_SAMPLE) begin
			chan_hold_q <= chsel_q;
		end
	end

	// ==========================================================
	// Result transfer and first-result validity.

	assign wide_value = {sar_q, RES_PAD};

	// Results load from the approximation register after the last bit.
	always_ff @(posedge mclk) begin
		if (rst) begin
			result_wide_q  <= RESULT_RESET;
			result_upper_q <= UPPER_RESET;
			done_q         <= 1'b0;
		end else begin
			done_q <= do_transfer;
			if (do_transfer) begin
				result_wide_q  <= wide_value;
				result_upper_q <= sar_q[RES_W-1:RES_W-8];
			end
		end
	end

	// A run started with the comparator off marks its first result invalid.
	always_ff @(posedge mclk) begin
		if (rst) begin
			first_q       <= 1'b0;
			ce_at_start_q <= 1'b0;
			invalid_q     <= 1'b0;
		end else begin
			if (start_conv) begin
				first_q       <= 1'b1;
				ce_at_start_q <= ce_bit;
			end else if (do_transfer) begin
				first_q   <= 1'b0;
				invalid_q <= first_q & ~ce_at_start_q;
			end
		end
	end

endmodule

/* File: test/sar_adc_control_chk.sv */
module sar_adc_control_chk
	import sar_adc_pkg::*;
(
	input logic                             mclk,
	input logic                             rst,
	input logic [sar_adc_pkg::ADDR_W-1:0]   bus_addr,
	input logic [sar_adc_pkg::DATA_W-1:0]   bus_wdata,
	input logic                             bus_wr,
	input logic                             bus_rd,
	input logic [sar_adc_pkg::DATA_W-1:0]   bus_rdata,
	input logic                             bus_wait,
	input logic                             comp_pin,
	input logic [sar_adc_pkg::RES_W-1:0]    trial_code,
	input logic                             sample_track,
	input logic                             hold_active,
	input logic                             comparator_power,
	input logic [sar_adc_pkg::CH_W-1:0]     input_mux_sel,
	input logic [sar_adc_pkg::NUM_PINS-1:0] analog_pin_en,
	input logic [1:0]                       voltage_range,
	input logic                             conversion_done_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Decodes of the accesses that the checks key on.
	wire mode_wr = bus_wr && bus_addr == MODE_ADDR;
	wire res_rd  = bus_rd && (bus_addr == RES_LO_ADDR || bus_addr == RES_HI_ADDR
		|| bus_addr == UPPER_ADDR);

	// ==========================================================
	// Register bus.
	rd_wait_a: assert property (res_rd |-> bus_wait)
		else $error("no wait flag on result read");
	wr_wait_a: assert property (mode_wr |-> bus_wait)
		else $error("no wait flag on mode write");
	wide_pad_a: assert property (bus_rd && bus_addr == RES_LO_ADDR |=> bus_rdata[5:0] == RES_PAD)
		else $error("wide result low bits not zero");
	upper_pad_a: assert property (res_rd && bus_addr != RES_LO_ADDR |=> bus_rdata[15:8] == 8'h00)
		else $error("byte result high bits not zero");

	// ==========================================================
	// Conversion control.
	stop_mode_a: assert property (mode_wr && bus_wdata[7:0] == 8'h00
		|-> ##3 !comparator_power && !sample_track && !hold_active) else $error("not stopped");
	wait_mode_a: assert property (mode_wr && !bus_wdata[RUN_BIT] && bus_wdata[CE_BIT]
		|-> ##3 comparator_power && !sample_track && !hold_active) else $error("not waiting");
	start_conv_a: assert property (mode_wr && bus_wdata[RUN_BIT] && !sample_track && !hold_active
		|-> ##[1:3] sample_track && comparator_power) else $error("conversion did not start");
	mux_hold_a: assert property (hold_active && $past(hold_active) |-> $stable(input_mux_sel))
		else $error("channel moved during hold");
	msb_first_a: assert property ($rose(hold_active) |-> ##[0:1] trial_code == RES_MSB_MASK)
		else $error("first trial is not the top bit");
	irq_pulse_a: assert property (conversion_done_irq |=> !conversion_done_irq)
		else $error("completion pulse too long");
	irq_cause_a: assert property (conversion_done_irq |-> $past(hold_active))
		else $error("completion without bit steps");
	irq_next_a: assert property (conversion_done_irq |-> ##[0:1] sample_track)
		else $error("next sample did not follow");

	// Main scenarios that the bench is expected to reach.
	conv_c: cover property (conversion_done_irq);
	rd_c: cover property (res_rd);
	abort_c: cover property (mode_wr && !bus_wdata[RUN_BIT] && hold_active);
endmodule

bind sar_adc_control sar_adc_control_chk u_sar_adc_control_chk (.mclk(mclk), .rst(rst),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .bus_wait(bus_wait), .comp_pin(comp_pin), .trial_code(trial_code),
	.sample_track(sample_track), .hold_active(hold_active), .comparator_power(comparator_power),
	.input_mux_sel(input_mux_sel), .analog_pin_en(analog_pin_en),
	.voltage_range(voltage_range), .conversion_done_irq(conversion_done_irq));

/* File: test/analog_front_model.sv */
module analog_front_model
	import sar_adc_pkg::*;
(
	input  logic                             mclk,
	input  logic [sar_adc_pkg::RES_W-1:0]    trial_code,
	input  logic                             sample_track,
	input  logic                             comparator_power,
	input  logic [sar_adc_pkg::CH_W-1:0]     input_mux_sel,
	input  logic [sar_adc_pkg::NUM_PINS-1:0] analog_pin_en,
	output logic                             comp_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [RES_W-1:0] level [NUM_PINS];
	logic [RES_W-1:0] held_q;

	// A pin that is not analog or does not exist gives no usable level.
	wire pin_ok = input_mux_sel < 3'h6 && analog_pin_en[input_mux_sel];

	// Tracks the selected pin while sampling and freezes it afterwards.
	always_ff @(posedge mclk) begin
		if (sample_track) begin
			held_q <= pin_ok ? level[input_mux_sel] : ~held_q;
		end
	end

	// An unpowered comparator sits low instead of answering.
	assign comp_pin = comparator_power ? held_q >= trial_code : 1'b0;
endmodule

/* File: test/sar_adc_control_bench.sv */
module sar_adc_control_bench
	import sar_adc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                mclk = 1'b0;
	logic                rst = 1'b1;
	logic [ADDR_W-1:0]   bus_addr = '0;
	logic [DATA_W-1:0]   bus_wdata = '0;
	logic                bus_wr = 1'b0;
	logic                bus_rd = 1'b0;
	logic [DATA_W-1:0]   bus_rdata;
	logic                bus_wait, comp_pin, sample_track, hold_active;
	logic                comparator_power, conversion_done_irq;
	logic [RES_W-1:0]    trial_code;
	logic [CH_W-1:0]     input_mux_sel;
	logic [NUM_PINS-1:0] analog_pin_en;
	logic [1:0]          voltage_range;
	logic [RES_W-1:0]    codes [6] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA, 10'h201, 10'h1FF};
	int                  bad_count = 0;
	int                  n_compared = 0;

	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;

	sar_adc_control u_sar_adc_control (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.bus_wait(bus_wait), .comp_pin(comp_pin), .trial_code(trial_code),
		.sample_track(sample_track), .hold_active(hold_active),
		.comparator_power(comparator_power), .input_mux_sel(input_mux_sel),
		.analog_pin_en(analog_pin_en), .voltage_range(voltage_range),
		.conversion_done_irq(conversion_done_irq));

	analog_front_model u_analog_front_model (.mclk(mclk), .trial_code(trial_code),
		.sample_track(sample_track), .comparator_power(comparator_power),
		.input_mux_sel(input_mux_sel), .analog_pin_en(analog_pin_en), .comp_pin(comp_pin));

	// ==========================================================
	// Shared tasks.
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge mclk);
		bus_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
		@(posedge mclk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1;
		chk(what, bus_rdata, exp);
	endtask

	// Waits for the next completion pulse, giving up after 300 cycles.
	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (conversion_done_irq !== 1'b1 && n < 300);
		chk("irq_seen", 16'(n < 300), 16'h0001);
	endtask

	task automatic summarize();
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_regs();
		rd(MODE_ADDR, 16'h0000, "mode_rst");
		rd(RES_LO_ADDR, 16'h0000, "wide_rst");
		rd(UPPER_ADDR, 16'h0000, "upper_rst");
		rd(16'h1234, 16'h0000, "unmapped");
		chk("pins_rst", 16'(analog_pin_en), 16'h003F);
		wr(PINCFG_ADDR, 16'h002A);
		chk("pins_cfg", 16'(analog_pin_en), 16'h002A);
		wr(PINCFG_ADDR, 16'h003F);
		wr(MODE_ADDR, 16'hAB56);
		rd(MODE_ADDR, 16'h0056, "mode_rw");
		chk("range", 16'(voltage_range), 16'h0003);
		chk("pwr_off", 16'(comparator_power), 16'h0000);
		wr(MODE_ADDR, 16'h0019);
		repeat (20) @(posedge mclk);
		#1;
		chk("wait_mode", 16'({comparator_power, sample_track, hold_active}), 16'h0004);
		wr(MODE_ADDR, 16'h0000);
		chk("stopped", 16'(comparator_power), 16'h0000);
	endtask

	// Divide-by-six conversion clock: the comparator filter needs five cycles per decision.
	task automatic t_conv(input int ch, input logic ce);
		u_analog_front_model.level[ch] = codes[ch];
		wr(CHSEL_ADDR, 16'(ch));
		if (ce) begin
			wr(MODE_ADDR, 16'h0011);
			repeat (110) @(posedge mclk);
		end
		wr(MODE_ADDR, {8'h00, 7'h48, ce});
		wait_irq();
		chk("mux_sel", 16'(input_mux_sel), 16'(ch));
		rd(STATUS_ADDR, {13'h0000, 1'b1, !ce, 1'b1}, "first_flag");
		rd(RES_LO_ADDR, {codes[ch], 6'h00}, "wide");
		rd(RES_HI_ADDR, {8'h00, codes[ch][9:2]}, "wide_hi");
		rd(UPPER_ADDR, {8'h00, codes[ch][9:2]}, "upper");
		wait_irq();
		rd(STATUS_ADDR, 16'h0005, "later_flag");
		wr(MODE_ADDR, {8'h00, 7'h08, ce});
	endtask

	task automatic t_abort();
		int seen;
		seen = 0;
		u_analog_front_model.level[2] = 10'h0F0;
		wr(CHSEL_ADDR, 16'h0002);
		wr(MODE_ADDR, 16'h0011);
		repeat (110) @(posedge mclk);
		wr(MODE_ADDR, 16'h0091);
		// Stop in the middle of the bit steps, well before the transfer.
		repeat (100) @(posedge mclk);
		wr(MODE_ADDR, 16'h0011);
		repeat (200) begin
			@(posedge mclk);
			#1;
			seen += int'(conversion_done_irq === 1'b1);
		end
		chk("abort_irq", 16'(seen), 16'h0000);
		chk("abort_idle", 16'({sample_track, hold_active}), 16'h0000);
		wr(RES_LO_ADDR, 16'hFFFF);
		rd(RES_LO_ADDR, {10'h1FF, 6'h00}, "kept_wide");
	endtask

	// Watchdog far beyond the roughly 3000 cycles the tests need.
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		summarize();
	end

	// Main sequence: reset for 10 cycles, then every scenario in turn.
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		for (int i = 0; i < 6; i++) begin
			t_conv(i, i != 5);
		end
		t_abort();
		summarize();
	end
endmodule
